// ---- include/cwd_pkg.sv ----
// Shared constants, field layout and decoded-settings types for the config word decoder.
// Assumes a 32-bit APB register bus with byte addresses held in eight bits.
package cwd_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFF_PWRUP   = 8'h00;
	localparam logic [7:0]  OFF_WDOG    = 8'h04;
	localparam logic [7:0]  OFF_OSCSEL  = 8'h08;
	localparam logic [7:0]  OFF_CTRL    = 8'h0c;
	localparam logic [7:0]  OFF_STATUS  = 8'h10;
	localparam logic [31:0] WORD_ERASED = 32'hffffffff;
	localparam logic [1:0]  CTRL_RST    = 2'h1;

	// ----------------------------------------------------------------
	// Field positions and reserved masks
	// ----------------------------------------------------------------
	localparam int LPBOR_BIT  = 3;
	localparam int RETENTION_REGULATOR_DISABLE_BIT  = 2;
	localparam int WDTEN_BIT  = 15;
	localparam int WINDOW_DISABLE_BIT = 7;
	localparam int CSM_LSB    = 14;
	localparam int SOSCX_BIT  = 12;
	localparam int CLKO_BIT   = 10;
	localparam int POSC_LSB   = 8;
	localparam int TWO_SPEED_STARTUP_ENABLE_BIT   = 7;
	localparam int SECONDARY_OSC_ENABLE_BIT = 6;
	localparam int PLLS_BIT   = 4;
	localparam logic [31:0] PWRUP_RSVD  = 32'hfffffff0;
	localparam logic [31:0] WDOG_RSVD   = 32'hffff0000;
	localparam logic [31:0] OSCSEL_RSVD = 32'hffff2828;
	localparam logic [4:0]  PS_MAX      = 5'h14;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] bor_mode;
		logic       lpbor;
		logic       retention_regulator_disable;
		logic       wdt_en;
		logic [1:0] wdt_clk;
		logic       wdt_clk_rsvd;
		logic [4:0] run_ps;
		logic [4:0] slp_ps;
		logic       win_en;
		logic [2:0] win_eighths;
		logic [2:0] osc_sel;
		logic       osc_rsvd;
		logic       clk_sw_en;
		logic       fscm_en;
		logic       pll_frc;
		logic       two_speed;
		logic       sosc_en;
		logic       sosc_xtal;
		logic       clko_io;
		logic [1:0] posc_mode;
		logic       rsvd_bad;
	} cwd_dec_s;

	typedef struct packed {
		cwd_dec_s    dec;
		logic        sw_bor;
		logic        runtime_retention_enable;
		logic        bor_en;
		logic        lpbor_en;
		logic        ret_en;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} cwd_state_s;

	// Postscale code to exponent, saturating at 2^20
	function automatic logic [4:0] cwd_ps_exp(input logic [4:0] code);
		cwd_ps_exp = (code > 5'h13) ? PS_MAX : code;
	endfunction : cwd_ps_exp

endpackage : cwd_pkg

// ---- include/cwd_nvm_if.sv ----
// Carrier between the decoder top and its configuration word store.
// Assumes one writer and any number of readers of the stored words.
`timescale 1ns/1ps
interface cwd_nvm_if;
	logic             wr_en;
	logic [1:0]       wr_idx;
	logic [31:0]      wr_data;
	logic [2:0][31:0] words;

	modport ctl (output wr_en, output wr_idx, output wr_data, input words);
	modport mem (input wr_en, input wr_idx, input wr_data, output words);
	modport dec (input words);
endinterface : cwd_nvm_if

// ---- hdl/cwd_nvm.sv ----
// Three nonvolatile configuration words, erased to all ones at power-on.
// Assumes device reset does not touch the stored words.
`timescale 1ns/1ps
module cwd_nvm (
	// Clock and power-on reset
	input  wire logic REF_CLK,
	input  wire logic POR_RESET,
	// Word port
	cwd_nvm_if.mem    nvm
);
	import cwd_pkg::*;

	typedef struct packed {
		logic [2:0][31:0] words;
	} cwd_nvm_s;

	cwd_nvm_s st_d;
	cwd_nvm_s st_q;

	always_comb begin
		st_d = st_q;
		if (POR_RESET) begin
			st_d.words = {3{WORD_ERASED}};
		end else if (nvm.wr_en && nvm.wr_idx != 2'h3) begin
			st_d.words[nvm.wr_idx] = nvm.wr_data;
		end
	end

	always_ff @(posedge REF_CLK) begin
		st_q <= st_d;
	end

	assign nvm.words = st_q.words;

endmodule : cwd_nvm

// ---- hdl/cwd_dec.sv ----
// Field decoder: turns the three stored words into decoded settings.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
module cwd_dec (
	// Stored words
	cwd_nvm_if.dec           nvm,
	// Decoded settings
	output cwd_pkg::cwd_dec_s dec
);
	import cwd_pkg::*;

	logic [31:0] pw;
	logic [31:0] wd;
	logic [31:0] os;

	assign pw = nvm.words[0];
	assign wd = nvm.words[1];
	assign os = nvm.words[2];

	always_comb begin
		dec              = '0;
		dec.bor_mode     = pw[1:0];
		dec.lpbor        = pw[LPBOR_BIT];
		dec.retention_regulator_disable        = pw[RETENTION_REGULATOR_DISABLE_BIT];
		dec.wdt_en       = wd[WDTEN_BIT];
		dec.wdt_clk      = wd[14:13];
		dec.wdt_clk_rsvd = (wd[14:13] == 2'h1);
		dec.run_ps       = cwd_ps_exp(wd[12:8]);
		dec.slp_ps       = cwd_ps_exp(wd[4:0]);
		dec.win_en       = ~wd[WINDOW_DISABLE_BIT];
		unique case (wd[6:5])
			2'h3: dec.win_eighths = 3'h2;
			2'h2: dec.win_eighths = 3'h3;
			2'h1: dec.win_eighths = 3'h4;
			2'h0: dec.win_eighths = 3'h6;
		endcase
		// Reserved codes fall back to fast RC with divider
		unique case (os[2:0])
			3'h3, 3'h6, 3'h7: begin
				dec.osc_sel  = 3'h0;
				dec.osc_rsvd = 1'b1;
			end
			default: begin
				dec.osc_sel  = os[2:0];
				dec.osc_rsvd = 1'b0;
			end
		endcase
		dec.clk_sw_en = os[CSM_LSB];
		dec.fscm_en   = os[CSM_LSB+1];
		dec.sosc_xtal = os[SOSCX_BIT];
		dec.clko_io   = os[CLKO_BIT];
		dec.posc_mode = os[POSC_LSB+:2];
		dec.two_speed = os[TWO_SPEED_STARTUP_ENABLE_BIT];
		dec.sosc_en   = os[SECONDARY_OSC_ENABLE_BIT];
		dec.pll_frc   = os[PLLS_BIT];
		dec.rsvd_bad  = ((pw & PWRUP_RSVD) != PWRUP_RSVD)
			| ((wd & WDOG_RSVD) != WDOG_RSVD)
			| ((os & OSCSEL_RSVD) != OSCSEL_RSVD);
	end

endmodule : cwd_dec

// ---- hdl/cwd_top.sv ----
// Config word decoder top: APB access to the words, latching and live control outputs.
// Assumes APB master on REF_CLK; SLEEP_MODE is synchronous to REF_CLK.
`timescale 1ns/1ps

module cwd_top (
	// Clock and resets
	input  wire logic        REF_CLK,
	input  wire logic        RESET,
	input  wire logic        POR_RESET,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic             PREADY,
	output logic [31:0]      PRDATA,
	output logic             PSLVERR,
	// Power state
	input  wire logic        SLEEP_MODE,
	// Supervisor controls
	output logic             BROWNOUT_RESET_EN,
	output logic             LOW_POWER_BROWNOUT_EN,
	output logic             RETENTION_REG_EN,
	// Watchdog controls
	output logic             WATCHDOG_ENABLE,
	output logic [1:0]       RUN_WATCHDOG_CLOCK_SELECT,
	output logic [4:0]       RUN_WATCHDOG_POSTSCALE,
	output logic [4:0]       SLEEP_WATCHDOG_POSTSCALE,
	output logic             WATCHDOG_WINDOW_EN,
	output logic [2:0]       WATCHDOG_WINDOW_SIZE,
	// Clock system controls
	output logic [2:0]       RESET_OSCILLATOR_SELECT,
	output logic             CLOCK_SWITCH_EN,
	output logic             CLOCK_MONITOR_EN,
	output logic             PLL_REFERENCE_SELECT,
	output logic             TWO_SPEED_STARTUP_ENABLE,
	output logic             SECONDARY_OSC_ENABLE,
	output logic             SECONDARY_OSC_EXTERNAL_CLOCK,
	output logic             CLOCK_OUTPUT_PIN_FUNCTION,
	output logic [1:0]       PRIMARY_OSC_MODE
);
	import cwd_pkg::*;

	// ----------------------------------------------------------------
	// Storage and decode
	// ----------------------------------------------------------------
	cwd_nvm_if  nvm ();
	cwd_dec_s   dec_w;
	cwd_state_s st_d;
	cwd_state_s st_q;

	logic        setup_ph;
	logic        first_acc;
	logic        done;
	logic        aligned;
	logic        hit;
	logic [31:0] rd_mux;

	cwd_nvm u_nvm (
		.REF_CLK   (REF_CLK),
		.POR_RESET (POR_RESET),
		.nvm       (nvm.mem)
	);

	cwd_dec u_dec (
		.nvm (nvm.dec),
		.dec (dec_w)
	);

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign setup_ph  = PSEL & ~PENABLE;
	assign first_acc = PSEL & PENABLE & ~st_q.pready;
	assign done      = PSEL & PENABLE & st_q.pready;
	assign aligned   = (PADDR[1:0] == 2'h0);
	assign hit       = aligned & (PADDR <= OFF_STATUS);

	assign nvm.wr_en   = done & PWRITE & aligned & (PADDR < OFF_CTRL);
	assign nvm.wr_idx  = PADDR[3:2];
	assign nvm.wr_data = PWDATA;

	always_comb begin
		rd_mux = '0;
		unique case (PADDR)
			OFF_PWRUP:  rd_mux = nvm.words[0];
			OFF_WDOG:   rd_mux = nvm.words[1];
			OFF_OSCSEL: rd_mux = nvm.words[2];
			OFF_CTRL:   rd_mux = {30'h0, st_q.runtime_retention_enable, st_q.sw_bor};
			OFF_STATUS: rd_mux = {26'h0, st_q.dec.rsvd_bad,
				st_q.dec.osc_rsvd, st_q.dec.wdt_clk_rsvd,
				st_q.ret_en, st_q.lpbor_en, st_q.bor_en};
			default:    rd_mux = '0;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d         = st_q;
		st_d.pready  = first_acc;
		st_d.pslverr = 1'b0;
		if (first_acc) begin
			st_d.pslverr = ~hit;
			st_d.prdata  = PWRITE ? 32'h0 : rd_mux;
		end
		if (done && PWRITE && PADDR == OFF_CTRL) begin
			st_d.sw_bor = PWDATA[0];
			st_d.runtime_retention_enable  = PWDATA[1];
		end
		// Brown-out reset from latched mode and live inputs
		unique case (st_q.dec.bor_mode)
			2'h3: st_d.bor_en = 1'b1;
			2'h2: st_d.bor_en = ~SLEEP_MODE;
			2'h1: st_d.bor_en = st_q.sw_bor;
			2'h0: st_d.bor_en = 1'b0;
		endcase
		st_d.lpbor_en = st_q.dec.lpbor & ~st_d.bor_en;
		st_d.ret_en   = ~st_q.dec.retention_regulator_disable
			& (~SLEEP_MODE | st_q.runtime_retention_enable);
		if (RESET) begin
			st_d.dec      = dec_w;
			st_d.sw_bor   = CTRL_RST[0];
			st_d.runtime_retention_enable    = CTRL_RST[1];
			st_d.bor_en   = 1'b0;
			st_d.lpbor_en = 1'b0;
			st_d.ret_en   = 1'b0;
			st_d.pready   = 1'b0;
			st_d.pslverr  = 1'b0;
			st_d.prdata   = '0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		st_q <= st_d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign PREADY                       = st_q.pready;
	assign PRDATA                       = st_q.prdata;
	assign PSLVERR                      = st_q.pslverr;
	assign BROWNOUT_RESET_EN            = st_q.bor_en;
	assign LOW_POWER_BROWNOUT_EN        = st_q.lpbor_en;
	assign RETENTION_REG_EN             = st_q.ret_en;
	assign WATCHDOG_ENABLE              = st_q.dec.wdt_en;
	assign RUN_WATCHDOG_CLOCK_SELECT    = st_q.dec.wdt_clk;
	assign RUN_WATCHDOG_POSTSCALE       = st_q.dec.run_ps;
	assign SLEEP_WATCHDOG_POSTSCALE     = st_q.dec.slp_ps;
	assign WATCHDOG_WINDOW_EN           = st_q.dec.win_en;
	assign WATCHDOG_WINDOW_SIZE         = st_q.dec.win_eighths;
	assign RESET_OSCILLATOR_SELECT      = st_q.dec.osc_sel;
	assign CLOCK_SWITCH_EN              = st_q.dec.clk_sw_en;
	assign CLOCK_MONITOR_EN             = st_q.dec.fscm_en;
	assign PLL_REFERENCE_SELECT         = st_q.dec.pll_frc;
	assign TWO_SPEED_STARTUP_ENABLE     = st_q.dec.two_speed;
	assign SECONDARY_OSC_ENABLE         = st_q.dec.sosc_en;
	assign SECONDARY_OSC_EXTERNAL_CLOCK = st_q.dec.sosc_xtal;
	assign CLOCK_OUTPUT_PIN_FUNCTION    = st_q.dec.clko_io;
	assign PRIMARY_OSC_MODE             = st_q.dec.posc_mode;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RESET);

	sequence s_setup;
		PSEL && !PENABLE;
	endsequence

	sequence s_access;
		PSEL && PENABLE;
	endsequence

	sequence s_reset_release;
		RESET ##1 !RESET;
	endsequence

	a_apb_ready_two: assert property (
		s_setup ##1 s_access |-> PREADY == 1'b0 ##1 PREADY)
		else $error("APB answer not in second access cycle");

	a_bor_hw_on: assert property (
		st_q.dec.bor_mode == 2'h3 |=> BROWNOUT_RESET_EN)
		else $error("Brown-out reset off in hardware-on mode");

	a_bor_run_only: assert property (
		st_q.dec.bor_mode == 2'h2 |=>
		BROWNOUT_RESET_EN == !$past(SLEEP_MODE))
		else $error("Brown-out reset wrong in run-only mode");

	a_bor_software: assert property (
		st_q.dec.bor_mode == 2'h1 |=>
		BROWNOUT_RESET_EN == $past(st_q.sw_bor))
		else $error("Brown-out reset ignores software enable");

	a_bor_hw_off: assert property (
		st_q.dec.bor_mode == 2'h0 |=> !BROWNOUT_RESET_EN)
		else $error("Brown-out reset on in hardware-off mode");

	a_lpbor_gate: assert property (
		1'b1 |=> LOW_POWER_BROWNOUT_EN ==
		($past(st_q.dec.lpbor) && !BROWNOUT_RESET_EN))
		else $error("Low-power brown-out gating wrong");

	a_retention_gate: assert property (
		1'b1 |=> RETENTION_REG_EN == (!$past(st_q.dec.retention_regulator_disable)
		&& (!$past(SLEEP_MODE) || $past(st_q.runtime_retention_enable))))
		else $error("Retention regulator enable wrong");

	a_fields_held: assert property (
		!$past(RESET) |-> $stable(st_q.dec))
		else $error("Latched fields changed without reset");

	a_latch_watchdog: assert property (disable iff (1'b0)
		s_reset_release |-> WATCHDOG_ENABLE ==
		$past(nvm.words[1][WDTEN_BIT], 2))
		else $error("Watchdog enable not latched at reset");

	a_run_postscale: assert property (disable iff (1'b0)
		s_reset_release |-> RUN_WATCHDOG_POSTSCALE ==
		(($past(nvm.words[1][12:8], 2) > 5'h13) ? 5'h14
		: $past(nvm.words[1][12:8], 2)))
		else $error("Run postscale decode wrong");

	a_sleep_postscale: assert property (disable iff (1'b0)
		s_reset_release |-> SLEEP_WATCHDOG_POSTSCALE ==
		(($past(nvm.words[1][4:0], 2) > 5'h13) ? 5'h14
		: $past(nvm.words[1][4:0], 2)))
		else $error("Sleep postscale decode wrong");

	a_window_size: assert property (disable iff (1'b0)
		s_reset_release ##0 ($past(nvm.words[1][6:5], 2) == 2'h2)
		|-> WATCHDOG_WINDOW_SIZE == 3'h3)
		else $error("Window size 37.5 percent decode wrong");

	a_window_mode: assert property (disable iff (1'b0)
		s_reset_release |-> WATCHDOG_WINDOW_EN ==
		!$past(nvm.words[1][WINDOW_DISABLE_BIT], 2))
		else $error("Window mode decode wrong");

	a_osc_reserved: assert property (disable iff (1'b0)
		s_reset_release ##0 ($past(nvm.words[2][2:0], 2) == 3'h3)
		|-> RESET_OSCILLATOR_SELECT == 3'h0)
		else $error("Reserved oscillator code not mapped");

	a_clock_switch: assert property (disable iff (1'b0)
		s_reset_release |-> {CLOCK_MONITOR_EN, CLOCK_SWITCH_EN} ==
		$past(nvm.words[2][CSM_LSB+:2], 2))
		else $error("Clock switch field decode wrong");

	a_run_clock: assert property (disable iff (1'b0)
		s_reset_release ##0 ($past(nvm.words[1][14:13], 2) == 2'h3)
		|-> RUN_WATCHDOG_CLOCK_SELECT == 2'h3)
		else $error("Low-power run clock code not latched");

	a_run_clock_any: assert property (disable iff (1'b0)
		s_reset_release |-> RUN_WATCHDOG_CLOCK_SELECT ==
		$past(nvm.words[1][14:13], 2))
		else $error("Run clock field not latched");

	a_apb_unaligned: assert property (
		s_setup ##1 (s_access && PADDR[1:0] != 2'h0) |=> PREADY && PSLVERR)
		else $error("Unaligned access not refused");

endmodule : cwd_top

// ---- test/cwd_prog_model.sv ----
// Programming tool model: APB master that writes and reads the configuration words.
// Assumes the slave answers with PREADY sampled on REF_CLK rising edges.
`timescale 1ns/1ps
module cwd_prog_model (
	// Clock
	input  wire logic        ref_clk,
	// APB master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	import cwd_pkg::*;

	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
	end

	// ----------------------------------------------------------------
	// One transfer, held until PREADY or for at most 64 access cycles
	// ----------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		rd = 'x;
		er = 1'bx;
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (pready === 1'b1) begin
			rd = prdata;
			er = pslverr;
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		paddr   <= ~a;
		pwdata  <= ~d;
	endtask : xfer

	// ----------------------------------------------------------------
	// Word programming, reserved bits forced to one
	// ----------------------------------------------------------------
	task automatic prog(input logic [1:0] idx, input logic [31:0] v, output logic [31:0] sent);
		logic [31:0] rd;
		logic        er;
		case (idx)
			2'h0: sent = v | PWRUP_RSVD;
			2'h1: sent = v | WDOG_RSVD;
			default: sent = v | OSCSEL_RSVD;
		endcase
		xfer(1'b1, {4'h0, idx, 2'h0}, sent, rd, er);
	endtask : prog
endmodule : cwd_prog_model

// ---- test/cwd_tb_top.sv ----
// Testbench top for the config word decoder.
// Assumes the programming tool model drives the APB side.
`timescale 1ns/1ps
module cwd_tb_top;
	import cwd_pkg::*;
	logic        ref_clk;
	logic        reset;
	logic        por_reset;
	logic        sleep_mode;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	wire logic        pready;
	wire logic        pslverr;
	wire logic [31:0] prdata;
	wire logic [2:0]  lv;
	wire logic [28:0] dv;
	int          err_total = 0;
	int          comparisons = 0;

	// ----------------------------------------------------------------
	// Design and programmer
	// ----------------------------------------------------------------
	cwd_top u_dut (
		.REF_CLK(ref_clk), .RESET(reset), .POR_RESET(por_reset),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .SLEEP_MODE(sleep_mode),
		.BROWNOUT_RESET_EN(lv[0]), .LOW_POWER_BROWNOUT_EN(lv[1]), .RETENTION_REG_EN(lv[2]),
		.WATCHDOG_ENABLE(dv[28]), .RUN_WATCHDOG_CLOCK_SELECT(dv[27:26]),
		.RUN_WATCHDOG_POSTSCALE(dv[25:21]), .SLEEP_WATCHDOG_POSTSCALE(dv[20:16]),
		.WATCHDOG_WINDOW_EN(dv[15]), .WATCHDOG_WINDOW_SIZE(dv[14:12]),
		.RESET_OSCILLATOR_SELECT(dv[11:9]), .CLOCK_SWITCH_EN(dv[8]), .CLOCK_MONITOR_EN(dv[7]),
		.PLL_REFERENCE_SELECT(dv[6]), .TWO_SPEED_STARTUP_ENABLE(dv[5]), .SECONDARY_OSC_ENABLE(dv[4]),
		.SECONDARY_OSC_EXTERNAL_CLOCK(dv[3]), .CLOCK_OUTPUT_PIN_FUNCTION(dv[2]),
		.PRIMARY_OSC_MODE(dv[1:0])
	);
	cwd_prog_model u_prog (
		.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr)
	);

	// ----------------------------------------------------------------
	// Expectations and checks
	// ----------------------------------------------------------------
	function automatic logic [4:0] sat(input logic [4:0] c);
		return (c > 5'h13) ? 5'h14 : c;
	endfunction : sat

	function automatic logic [28:0] exp_dec(input logic [31:0] w, input logic [31:0] o);
		logic [2:0] win;
		logic [2:0] osc;
		win = (w[6:5] == 2'h3) ? 3'h2 : (w[6:5] == 2'h2) ? 3'h3 : (w[6:5] == 2'h1) ? 3'h4 : 3'h6;
		osc = (o[2:0] == 3'h3 || o[2:0] > 3'h5) ? 3'h0 : o[2:0];
		return {w[15], w[14:13], sat(w[12:8]), sat(w[4:0]), !w[7], win, osc,
			o[14], o[15], o[4], o[7], o[6], o[12], o[10], o[9:8]};
	endfunction : exp_dec

	function automatic logic [2:0] exp_live(input logic [31:0] p, input logic s, input logic [1:0] c);
		logic b;
		case (p[1:0])
			2'h3: b = 1'b1;
			2'h2: b = !s;
			2'h1: b = c[0];
			default: b = 1'b0;
		endcase
		return {!p[2] && (!s || c[1]), p[3] && !b, b};
	endfunction : exp_live

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic close_out();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out

	task automatic dev_reset();
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		chk({29'h0, lv}, 32'h0);
		@(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
	endtask : dev_reset

	// ----------------------------------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (6000) @(posedge ref_clk);
		err_total++;
		close_out();
	end

	initial begin
		logic [31:0] pw, wd, os, rd, wds, oss;
		logic        er;
		reset = 1'b1;
		por_reset = 1'b1;
		sleep_mode = 1'b0;
		void'($urandom(23));
		repeat (3) @(posedge ref_clk);
		por_reset <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		u_prog.xfer(1'b0, OFF_CTRL, 32'h0, rd, er);
		chk(rd, 32'h1);
		chk({31'h0, er}, 32'h0);
		wds = WORD_ERASED;
		oss = WORD_ERASED;
		for (int i = 0; i < 8; i++) begin
			pw = $urandom();
			pw[1:0] = i[1:0];
			wd = $urandom();
			wd[14:13] = i[1:0];
			wd[6:5] = i[2:1];
			if (i == 0) begin
				wd[12:8] = 5'h13;
				wd[4:0] = 5'h14;
			end
			if (i == 1) begin
				wd[12:8] = 5'h1f;
				wd[4:0] = 5'h00;
			end
			os = $urandom();
			os[2:0] = i[2:0];
			os[15:14] = i[1:0];
			u_prog.prog(2'h0, pw, pw);
			u_prog.prog(2'h1, wd, wd);
			u_prog.prog(2'h2, os, os);
			u_prog.xfer(1'b1, 8'h01, 32'h0, rd, er);
			chk({31'h0, er}, 32'h1);
			for (int j = 0; j < 3; j++) begin
				u_prog.xfer(1'b0, 8'(j * 4), 32'h0, rd, er);
				chk(rd, (j == 0) ? pw : (j == 1) ? wd : os);
			end
			chk({3'h0, dv}, {3'h0, exp_dec(wds, oss)});
			dev_reset();
			chk({3'h0, dv}, {3'h0, exp_dec(wd, os)});
			wds = wd;
			oss = os;
			for (int k = 0; k < 8; k++) begin
				u_prog.xfer(1'b1, OFF_CTRL, 32'(k & 3), rd, er);
				sleep_mode <= k[2];
				repeat (3) @(posedge ref_clk);
				chk({29'h0, lv}, {29'h0, exp_live(pw, k[2], k[1:0])});
			end
			u_prog.xfer(1'b1, OFF_STATUS, 32'hffffffff, rd, er);
			u_prog.xfer(1'b0, OFF_STATUS, 32'h0, rd, er);
			chk(rd & 32'h3f, {26'h0, 1'b0, (os[2:0] == 3'h3 || os[2:0] > 3'h5), (wd[14:13] == 2'h1),
				exp_live(pw, 1'b1, 2'h3)});
			u_prog.xfer(1'b0, 8'h14, 32'h0, rd, er);
			chk({31'h0, er}, 32'h1);
		end
		close_out();
	end
endmodule : cwd_tb_top
